//--- hdl/sid_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz reference clock
// Notes: Included by sid_scroll, sid_top and the dv files of the status indicator
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH
// Register byte offsets
`define SID_ADR_CTRL 8'h00
`define SID_ADR_SHOW 8'h04
`define SID_ADR_ISTAT 8'h08
`define SID_ADR_IMASK 8'h0C
// Control register fields
`define SID_CTRL_INV 0
`define SID_CTRL_LOFF 1
`define SID_CTRL_RST 2'h0
`define SID_IMASK_RST 4'h0
// Interrupt status bit positions
`define SID_EV_ERR 0
`define SID_EV_RESTART 1
`define SID_EV_LOFF 2
`define SID_EV_ILOCK 3
// Character codes: 0..F are hex digits, then blank
`define SID_CH_BLANK 5'h10
// Highest area shown static
`define SID_AREA_STATIC 8'h20
// Timing in ms and the clock rate in kHz
`define SID_CLK_KHZ 100000
`define SID_STEP_MS 250
`define SID_HOLD_MS 1000
`endif

//--- hdl/sid_pkg.sv
// Purpose: Types shared by the status indicator modules
// Assumes: Nothing beyond the defines header
// Notes: State of each module is one packed struct
package sid_pkg;
    // Restart sequencer states
    typedef enum logic [1:0] {
        SID_RS_IDLE,
        SID_RS_HOLD,
        SID_RS_DONE
    } sid_rs_e;
    // Character code for one display digit
    typedef logic [4:0] sid_char_t;
endpackage

//--- hdl/sid_seg_enc.sv
// Purpose: Character to seven-segment pattern, optionally rotated
// Assumes: Segment bits are g f e d c b a, high lights a segment
// Notes: Pure logic, no state
`timescale 1ns/1ps
module sid_seg_enc (
    // Character and orientation
    input wire logic [4:0] char_i,
    input wire logic flip_i,
    // Segment pattern
    output logic [6:0] seg_o
);
    // Hex glyphs, indexed by character
    localparam logic [6:0] GLYPH [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F,
        7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39,
        7'h5E, 7'h79, 7'h71};
    logic [6:0] upright;

    // Lookup; anything above hex F is blank
    always_comb begin
        upright = char_i[4] ? 7'h00 : GLYPH[char_i[3:0]];
    end

    // Rotating 180 degrees swaps a/d, b/e and c/f
    assign seg_o = flip_i ? {upright[6], upright[2:0], upright[5:3]} :
        upright;
endmodule

//--- hdl/sid_scroll.sv
// Purpose: Scrolls a three-character number across two digits
// Assumes: Step period long against the clock
// Notes: Text enters at the right and leaves at the left
`timescale 1ns/1ps
`include "sid_defs.svh"
module sid_scroll #(
    parameter int unsigned STEP_CYC = `SID_STEP_MS * `SID_CLK_KHZ
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Text to scroll
    input wire logic run_i,
    input wire logic [14:0] text_i,
    // Characters for the left and right digit
    output logic [4:0] left_o,
    output logic [4:0] right_o
);
    typedef struct packed {
        logic [2:0] pos;
        logic [31:0] cnt;
    } sid_scr_s;

    sid_scr_s state_reg;
    sid_scr_s state_next;
    logic [4:0] ring [0:4];

    // Two blanks trail the text so it clears before wrapping
    always_comb begin
        ring[0] = text_i[14:10];
        ring[1] = text_i[9:5];
        ring[2] = text_i[4:0];
        ring[3] = `SID_CH_BLANK;
        ring[4] = `SID_CH_BLANK;
    end

    // Step counter and ring position
    always_comb begin
        state_next = state_reg;
        if (!run_i) begin
            state_next.pos = 3'h4;
            state_next.cnt = 32'h0000_0000;
        end else if (state_reg.cnt >= STEP_CYC - 1) begin
            state_next.cnt = 32'h0000_0000;
            state_next.pos = (state_reg.pos == 3'h4) ? 3'h0 :
                3'(state_reg.pos + 3'h1);
        end else begin
            state_next.cnt = state_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '{pos: 3'h4, cnt: 32'h0000_0000};
        end else begin
            state_reg <= state_next;
        end
    end

    // Window of two over the ring
    assign left_o = ring[state_reg.pos];
    assign right_o = ring[(state_reg.pos == 3'h4) ? 3'h0 :
        3'(state_reg.pos + 3'h1)];
endmodule

//--- hdl/sid_top.sv
// Purpose: Front-panel lamps and two-digit status display
// Assumes: Status inputs come from logic on ref_clk_i
// Notes: Outputs are registered; register port answers next cycle
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sid_defs.svh"
module sid_top #(
    parameter int unsigned STEP_CYC = `SID_STEP_MS * `SID_CLK_KHZ,
    parameter int unsigned HOLD_CYC = `SID_HOLD_MS * `SID_CLK_KHZ
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    // Safety and warning output states
    input wire logic pair1_on_i,
    input wire logic pair2_on_i,
    input wire logic pair2_used_i,
    input wire logic warn1_off_i,
    input wire logic warn1_used_i,
    input wire logic warn2_off_i,
    input wire logic warn2_used_i,
    input wire logic ilock1_i,
    input wire logic ilock2_i,
    input wire logic mute1_i,
    input wire logic mute2_i,
    // Operating conditions
    input wire logic init_i,
    input wire logic setting_i,
    input wire logic encoder_mode_i,
    input wire logic [7:0] area_i,
    input wire logic err_i,
    input wire logic [7:0] err_code_i,
    input wire logic card_found_i,
    input wire logic card_apply_i,
    input wire logic card_ok_i,
    input wire logic card_restart_i,
    input wire logic addr_reset_done_i,
    // Lamps
    output logic lamp_p1_grn_o,
    output logic lamp_p1_red_o,
    output logic lamp_p2_grn_o,
    output logic lamp_p2_red_o,
    output logic lamp_warn1_o,
    output logic lamp_warn2_o,
    output logic lamp_ilock1_o,
    output logic lamp_ilock2_o,
    // Display, left and right digit
    output logic [6:0] seg_left_o,
    output logic [6:0] seg_right_o,
    output logic [1:0] dot_o,
    // Laser and safety control
    output logic laser_en_o,
    output logic force_off_o,
    output logic restart_o
);
    typedef struct packed {
        logic [7:0] lamps;
        logic [6:0] seg_l;
        logic [6:0] seg_r;
        logic [1:0] dots;
        logic laser_en;
        logic force_off;
        logic restart;
        logic fb_kind;
        sid_pkg::sid_rs_e rs;
        logic [31:0] rs_cnt;
        logic [1:0] ctrl;
        logic [3:0] istat;
        logic [3:0] imask;
        logic [3:0] ev_prev;
        logic [9:0] shown;
        logic [31:0] rdata;
        logic irq;
    } sid_top_s;

    sid_top_s state_reg;
    sid_top_s state_next;
    sid_pkg::sid_char_t ch_l; // Left character before orientation
    sid_pkg::sid_char_t ch_r; // Right character before orientation
    sid_pkg::sid_char_t scr_l;
    sid_pkg::sid_char_t scr_r;
    sid_pkg::sid_char_t dig_ch [0:1]; // Characters after any swap
    logic [6:0] dig_seg [0:1];
    logic [3:0] hund;
    logic [6:0] rem7;
    logic [3:0] tens;
    logic [3:0] ones;
    logic big_area; // Area above the static range in encoder mode
    logic loff_act; // Laser-off area in effect
    logic inv;
    logic [3:0] ev_now;

    // Area number into decimal digits
    always_comb begin
        hund = (area_i >= 8'h64) ? 4'h1 : 4'h0;
        rem7 = (area_i >= 8'h64) ? 7'(area_i - 8'h64) : area_i[6:0];
        tens = 4'(rem7 / 7'h0A);
        ones = 4'(rem7 % 7'h0A);
    end

    assign inv = state_reg.ctrl[`SID_CTRL_INV];
    assign big_area = (area_i > `SID_AREA_STATIC) && encoder_mode_i;
    // Area 1 is reserved once laser-off mode is on
    assign loff_act = state_reg.ctrl[`SID_CTRL_LOFF] &&
        (area_i == 8'h01);

    sid_scroll #(
        .STEP_CYC(STEP_CYC)
    ) u_scroll (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(big_area),
        .text_i({((hund == 4'h0) ? `SID_CH_BLANK : {1'b0, hund}),
            {1'b0, tens}, {1'b0, ones}}),
        .left_o(scr_l),
        .right_o(scr_r)
    );

    // Code selection in fixed priority order
    always_comb begin
        ch_l = {1'b0, err_code_i[7:4]};
        ch_r = {1'b0, err_code_i[3:0]};
        if (err_i) begin
            ch_l = {1'b0, err_code_i[7:4]};
        end else if (state_reg.rs != sid_pkg::SID_RS_IDLE) begin
            ch_l = 5'h0F;
            ch_r = state_reg.fb_kind ? 5'h0B : 5'h05;
        end else if (card_ok_i) begin
            ch_l = 5'h0F;
            ch_r = 5'h04;
        end else if (card_apply_i) begin
            ch_l = 5'h0F;
            ch_r = 5'h03;
        end else if (card_found_i) begin
            ch_l = 5'h0F;
            ch_r = 5'h02;
        end else if (init_i) begin
            ch_l = 5'h00;
            ch_r = 5'h00;
        end else if (setting_i) begin
            ch_l = 5'h03;
            ch_r = 5'h03;
        end else if (loff_act) begin
            ch_l = 5'h04;
            ch_r = 5'h00;
        end else if (mute1_i || mute2_i) begin
            ch_l = 5'h03;
            ch_r = (mute1_i && mute2_i) ? 5'h09 :
                (mute1_i ? 5'h07 : 5'h08);
        end else if (ilock1_i || ilock2_i) begin
            ch_l = 5'h03;
            ch_r = (ilock1_i && ilock2_i) ? 5'h06 :
                (ilock1_i ? 5'h04 : 5'h05);
        end else if (big_area) begin
            ch_l = scr_l;
            ch_r = scr_r;
        end else begin
            ch_l = {1'b0, tens};
            ch_r = {1'b0, ones};
        end
    end

    // Upside down: right character goes to the left digit
    always_comb begin
        dig_ch[0] = inv ? ch_r : ch_l;
        dig_ch[1] = inv ? ch_l : ch_r;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dig
            sid_seg_enc u_enc (
                .char_i(dig_ch[gi]),
                .flip_i(inv),
                .seg_o(dig_seg[gi])
            );
        end
    endgenerate

    // Events that raise sticky status bits
    always_comb begin
        ev_now = 4'h0;
        ev_now[`SID_EV_ERR] = err_i;
        ev_now[`SID_EV_RESTART] = state_reg.restart;
        ev_now[`SID_EV_LOFF] = loff_act;
        ev_now[`SID_EV_ILOCK] = ilock1_i || ilock2_i;
    end

    // Next state of lamps, display, sequencer and registers
    always_comb begin
        state_next = state_reg;
        // Forced-off pair one shows red even before the core reacts
        state_next.lamps[0] = pair1_on_i && !loff_act;
        state_next.lamps[1] = !(pair1_on_i && !loff_act);
        state_next.lamps[2] = !pair2_used_i ||
            (pair2_on_i && !loff_act);
        state_next.lamps[3] = !state_next.lamps[2];
        state_next.lamps[4] = warn1_used_i && warn1_off_i;
        state_next.lamps[5] = warn2_used_i && warn2_off_i;
        state_next.lamps[6] = ilock1_i;
        state_next.lamps[7] = ilock2_i;
        state_next.seg_l = dig_seg[0];
        state_next.seg_r = dig_seg[1];
        state_next.dots = {inv, inv};
        state_next.laser_en = !loff_act;
        state_next.force_off = loff_act;
        state_next.shown = {ch_l, ch_r};
        // Restart code is held for a while, then restart is asked
        case (state_reg.rs)
            sid_pkg::SID_RS_IDLE: begin
                if (addr_reset_done_i || card_restart_i) begin
                    state_next.rs = sid_pkg::SID_RS_HOLD;
                    state_next.fb_kind = addr_reset_done_i;
                    state_next.rs_cnt = 32'h0000_0000;
                end
            end
            sid_pkg::SID_RS_HOLD: begin
                if (state_reg.rs_cnt >= HOLD_CYC - 1) begin
                    state_next.rs = sid_pkg::SID_RS_DONE;
                    state_next.restart = 1'b1;
                end else begin
                    state_next.rs_cnt = state_reg.rs_cnt + 32'h0000_0001;
                end
            end
            sid_pkg::SID_RS_DONE: begin
                state_next.restart = 1'b1;
            end
            default: begin
                state_next.rs = sid_pkg::SID_RS_IDLE;
            end
        endcase
        // Register writes; write-one clears, a new event wins
        state_next.ev_prev = ev_now;
        if (reg_wr_i && reg_addr_i == `SID_ADR_CTRL) begin
            state_next.ctrl = reg_wdata_i[1:0];
        end
        if (reg_wr_i && reg_addr_i == `SID_ADR_IMASK) begin
            state_next.imask = reg_wdata_i[3:0];
        end
        if (reg_wr_i && reg_addr_i == `SID_ADR_ISTAT) begin
            state_next.istat = state_reg.istat & ~reg_wdata_i[3:0];
        end
        state_next.istat = state_next.istat |
            (ev_now & ~state_reg.ev_prev);
        // Reads answer in the next cycle; unmapped reads give zero
        state_next.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SID_ADR_CTRL: state_next.rdata = {30'h0, state_reg.ctrl};
                `SID_ADR_SHOW: state_next.rdata = {22'h0, state_reg.shown};
                `SID_ADR_ISTAT: state_next.rdata = {28'h0, state_reg.istat};
                `SID_ADR_IMASK: state_next.rdata = {28'h0, state_reg.imask};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        state_next.irq = |(state_next.istat & state_next.imask);
    end

    // Single state register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.lamps <= 8'h0A; // Both pairs red
            state_reg.ctrl <= `SID_CTRL_RST;
            state_reg.imask <= `SID_IMASK_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign lamp_p1_grn_o = state_reg.lamps[0];
    assign lamp_p1_red_o = state_reg.lamps[1];
    assign lamp_p2_grn_o = state_reg.lamps[2];
    assign lamp_p2_red_o = state_reg.lamps[3];
    assign lamp_warn1_o = state_reg.lamps[4];
    assign lamp_warn2_o = state_reg.lamps[5];
    assign lamp_ilock1_o = state_reg.lamps[6];
    assign lamp_ilock2_o = state_reg.lamps[7];
    assign seg_left_o = state_reg.seg_l;
    assign seg_right_o = state_reg.seg_r;
    assign dot_o = state_reg.dots;
    assign laser_en_o = state_reg.laser_en;
    assign force_off_o = state_reg.force_off;
    assign restart_o = state_reg.restart;
    assign reg_rdata_o = state_reg.rdata;
    assign irq_o = state_reg.irq;

    // Checks beside the logic
    a_pair1_lamp: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        pair1_on_i && !loff_act |=> lamp_p1_grn_o && !lamp_p1_red_o)
        else $error("pair one lamp not green");
    a_pair2_unused: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !pair2_used_i |=> lamp_p2_grn_o && !lamp_p2_red_o)
        else $error("unused pair two not green");
    a_warn_dark: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !warn1_used_i |=> !lamp_warn1_o)
        else $error("unused warning lamp lit");
    a_ilock_lamp: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ##1 lamp_ilock2_o == $past(ilock2_i))
        else $error("interlock lamp wrong");
    a_init_code: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        init_i && !err_i && state_reg.rs == sid_pkg::SID_RS_IDLE &&
        !card_found_i && !card_apply_i && !card_ok_i
        |=> state_reg.shown == 10'h000)
        else $error("init code not 00");
    a_loff_stop: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        loff_act |=> !laser_en_o && force_off_o && !lamp_p1_grn_o)
        else $error("laser-off area not honoured");
    a_inv_dots: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $rose(inv) |=> dot_o == 2'h3)
        else $error("dots not lit when inverted");
    a_fb_restart: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        state_reg.rs == sid_pkg::SID_RS_IDLE && addr_reset_done_i
        |=> state_reg.fb_kind && !restart_o)
        else $error("address reset sequence wrong");
    a_err_first: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        err_i |=> state_reg.shown == {1'b0, $past(err_code_i[7:4]),
            1'b0, $past(err_code_i[3:0])})
        else $error("error code not shown first");
endmodule

//--- dv/sid_panel.sv
// Purpose: Panel model; reads both digits back as characters
// Assumes: Segment bits g f e d c b a, high lights a segment
// Notes: Unknown patterns read as 5'h1F so they never match
`timescale 1ns/1ps
`include "sid_defs.svh"
module sid_panel (
    // Display as the block drives it
    input wire logic [6:0] seg_left_i,
    input wire logic [6:0] seg_right_i,
    input wire logic [1:0] dot_i,
    // Characters as a viewer reads them
    output sid_pkg::sid_char_t left_o,
    output sid_pkg::sid_char_t right_o
);
    // Usual hex glyphs
    localparam logic [6:0] PAT [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
        7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E,
        7'h79, 7'h71};
    // Half turn back: a and d, b and e, c and f trade places
    function automatic logic [6:0] turn(input logic [6:0] s);
        return {s[6], s[2], s[1], s[0], s[5], s[4], s[3]};
    endfunction

    // Glyph to character; dark digit is the blank character
    function automatic logic [4:0] decode(input logic [6:0] s);
        logic [4:0] ch;
        ch = (s == 7'h00) ? `SID_CH_BLANK : 5'h1F;
        for (int i = 0; i < 16; i++) begin
            if (s == PAT[i]) begin
                ch = i[4:0];
            end
        end
        return ch;
    endfunction

    // Inverted: swap digits and turn back
    always_comb begin
        if (&dot_i) begin
            left_o = decode(turn(seg_right_i));
            right_o = decode(turn(seg_left_i));
        end else begin
            left_o = decode(seg_left_i);
            right_o = decode(seg_right_i);
        end
    end
endmodule

//--- dv/test_status_indicator_display.sv
// Purpose: Self-checking bench for the status lamps and display
// Assumes: Short scroll and hold counts
// Notes: Digits are judged through the panel model
`timescale 1ns/1ps
`include "sid_defs.svh"
module test_status_indicator_display;
    // Short counts; expectations derive from these
    localparam int STEP = 4;
    localparam int HOLD = 8;
    localparam logic [4:0] BL = `SID_CH_BLANK;
    // Clock, reset and register port
    logic ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, irq_o;
    logic [7:0] reg_addr_i, area_i, err_code_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    // Status inputs
    logic pair1_on_i, pair2_on_i, pair2_used_i, warn1_off_i, warn1_used_i;
    logic warn2_off_i, warn2_used_i, ilock1_i, ilock2_i, mute1_i, mute2_i;
    logic init_i, setting_i, encoder_mode_i, err_i, card_found_i;
    logic card_apply_i, card_ok_i, card_restart_i, addr_reset_done_i;
    // Lamps, display and control outputs
    logic lamp_p1_grn_o, lamp_p1_red_o, lamp_p2_grn_o, lamp_p2_red_o;
    logic lamp_warn1_o, lamp_warn2_o, lamp_ilock1_o, lamp_ilock2_o;
    logic [6:0] seg_left_o, seg_right_o;
    logic [1:0] dot_o;
    logic laser_en_o, force_off_o, restart_o;
    // Characters as the panel model reads them
    logic [4:0] left_seen, right_seen;
    // Tallies
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    sid_top #(.STEP_CYC(STEP), .HOLD_CYC(HOLD)) u_dut (.*);
    sid_panel u_panel (
        .seg_left_i(seg_left_o), .seg_right_i(seg_right_o), .dot_i(dot_o),
        .left_o(left_seen), .right_o(right_seen)
    );

    // Free-running 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;
    // Hang guard; the full run needs about 2000 cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            conclude();
        end
    end

    // Compare and tally
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Inputs taken at the next edge, outputs land one edge later
    task automatic look();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic show(input logic [4:0] l, input logic [4:0] r);
        check("left digit", l, left_seen);
        check("right digit", r, right_seen);
    endtask
    // One-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data stands only the cycle after
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(what, exp, reg_rdata_o);
    endtask
    task automatic do_reset();
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
    endtask

    // Quiet start: unused pair two green, unused warning dark
    task automatic t_reset();
        look();
        check("p1 red", 1, lamp_p1_red_o);
        check("p2 green", 1, lamp_p2_grn_o);
        check("warn1", 0, lamp_warn1_o);
        rd_chk("ctrl", `SID_ADR_CTRL, 32'h0000_0000);
        rd_chk("imask", `SID_ADR_IMASK, 32'h0000_0000);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        rd_chk("show", `SID_ADR_SHOW, 32'h0000_0005);
    endtask
    // Every lamp input combination
    task automatic t_lamps();
        logic [8:0] v;
        for (int i = 0; i < 512; i++) begin
            v = i[8:0];
            @(posedge ref_clk_i);
            {pair1_on_i, pair2_on_i, pair2_used_i, warn1_off_i, warn1_used_i,
             warn2_off_i, warn2_used_i, ilock1_i, ilock2_i} <= v;
            look();
            check("p1 green", v[8], lamp_p1_grn_o);
            check("p1 red", !v[8], lamp_p1_red_o);
            check("p2 green", v[7] | !v[6], lamp_p2_grn_o);
            check("p2 red", !v[7] & v[6], lamp_p2_red_o);
            check("warn1", v[5] & v[4], lamp_warn1_o);
            check("warn2", v[3] & v[2], lamp_warn2_o);
            check("ilock1", v[1], lamp_ilock1_o);
            check("ilock2", v[0], lamp_ilock2_o);
        end
        @(posedge ref_clk_i);
        {ilock1_i, ilock2_i} <= 2'b00;
    endtask
    // Initialising, then static areas
    task automatic t_areas();
        logic [7:0] a [4] = '{8'h01, 8'h13, 8'h20, 8'h20};
        @(posedge ref_clk_i);
        init_i <= 1'b1;
        look();
        show(5'h00, 5'h00);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk_i);
            init_i <= 1'b0;
            area_i <= a[k];
            encoder_mode_i <= (k == 3);
            look();
            show(a[k] / 10, a[k] % 10);
        end
        rd_chk("show", `SID_ADR_SHOW, 32'h0000_0062);
    endtask
    // Area 128 scrolls right to left, one step per STEP cycles
    task automatic t_scroll();
        logic [9:0] seen [$];
        int len [$];
        logic [9:0] exp [6] = '{{BL, 5'h01}, {5'h01, 5'h02},
            {5'h02, 5'h08}, {5'h08, BL}, {BL, BL}, {BL, 5'h01}};
        @(posedge ref_clk_i);
        area_i <= 8'h80;
        look();
        for (int c = 0; c < 40; c++) begin
            if (seen.size() == 0 || seen[$] !== {left_seen, right_seen}) begin
                seen.push_back({left_seen, right_seen});
                len.push_back(0);
            end
            len[len.size() - 1] += 1;
            @(posedge ref_clk_i);
            #1;
        end
        for (int k = 0; k < 6; k++) begin
            check("scroll window", exp[k], seen[k]);
        end
        for (int k = 1; k < 5; k++) begin
            check("scroll dwell", STEP, len[k]);
        end
    endtask
    // All conditions at once, then dropped one by one
    task automatic t_codes();
        logic [7:0] code [14] = '{8'hE7, 8'hF4, 8'hF3, 8'hF2, 8'h00, 8'h33,
            8'h40, 8'h39, 8'h37, 8'h38, 8'h36, 8'h34, 8'h35, 8'h07};
        reg_wr(`SID_ADR_CTRL, 32'h0000_0002);
        @(posedge ref_clk_i);
        {err_i, card_ok_i, card_apply_i, card_found_i, init_i} <= 5'h1F;
        {setting_i, mute1_i, mute2_i, ilock1_i, ilock2_i} <= 5'h1F;
        {pair1_on_i, pair2_on_i, pair2_used_i, encoder_mode_i} <= 4'hE;
        err_code_i <= 8'hE7;
        area_i <= 8'h01;
        for (int k = 0; k < 14; k++) begin
            look();
            show(code[k][7:4], code[k][3:0]);
            if (k == 6) begin
                check("laser", 0, laser_en_o);
                check("forced off", 1, force_off_o);
                check("p1 red", 1, lamp_p1_red_o);
                check("p2 red", 1, lamp_p2_red_o);
            end
            if (k == 7) begin
                check("laser", 1, laser_en_o);
                check("p1 green", 1, lamp_p1_grn_o);
            end
            @(posedge ref_clk_i);
            case (k)
                0: err_i <= 1'b0;
                1: card_ok_i <= 1'b0;
                2: card_apply_i <= 1'b0;
                3: card_found_i <= 1'b0;
                4: init_i <= 1'b0;
                5: setting_i <= 1'b0;
                6: area_i <= 8'h07;
                7: mute2_i <= 1'b0;
                8: {mute1_i, mute2_i} <= 2'b01;
                9: mute2_i <= 1'b0;
                10: ilock2_i <= 1'b0;
                11: {ilock1_i, ilock2_i} <= 2'b01;
                12: ilock2_i <= 1'b0;
                default: ;
            endcase
        end
    endtask
    // Sticky events, mask, write-one-to-clear
    task automatic t_irq();
        rd_chk("istat", `SID_ADR_ISTAT, 32'h0000_000D);
        check("irq masked", 0, irq_o);
        reg_wr(`SID_ADR_IMASK, 32'h0000_0008);
        look();
        check("irq", 1, irq_o);
        reg_wr(`SID_ADR_ISTAT, 32'h0000_0008);
        look();
        check("irq cleared", 0, irq_o);
        rd_chk("istat", `SID_ADR_ISTAT, 32'h0000_0005);
        @(posedge ref_clk_i);
        ilock1_i <= 1'b1;
        look();
        check("irq again", 1, irq_o);
        @(posedge ref_clk_i);
        ilock1_i <= 1'b0;
        reg_wr(`SID_ADR_ISTAT, 32'h0000_000F);
        look();
        check("irq end", 0, irq_o);
    endtask
    // Upside-down digits with both dots lit
    task automatic t_invert();
        @(posedge ref_clk_i);
        area_i <= 8'h0C;
        reg_wr(`SID_ADR_CTRL, 32'h0000_0001);
        look();
        check("dots", 2'b11, dot_o);
        show(5'h01, 5'h02);
        reg_wr(`SID_ADR_CTRL, 32'h0000_0000);
        look();
        check("dots", 2'b00, dot_o);
        show(5'h01, 5'h02);
    endtask
    // Address reset, then card restart, each after reset
    task automatic t_restart();
        for (int k = 0; k < 2; k++) begin
            do_reset();
            @(posedge ref_clk_i);
            addr_reset_done_i <= (k == 0);
            card_restart_i <= (k == 1);
            @(posedge ref_clk_i);
            {addr_reset_done_i, card_restart_i} <= 2'b00;
            @(posedge ref_clk_i);
            #1;
            show(5'h0F, (k == 0) ? 5'h0B : 5'h05);
            check("restart early", 0, restart_o);
            repeat (HOLD + 2) @(posedge ref_clk_i);
            #1;
            check("restart", 1, restart_o);
            rd_chk("istat", `SID_ADR_ISTAT, 32'h0000_0002);
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        ref_clk_i = 1'b0;
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, err_code_i} = '0;
        {pair1_on_i, pair2_on_i, pair2_used_i, warn1_used_i, warn2_off_i,
         warn2_used_i, ilock1_i, ilock2_i, mute1_i, mute2_i, init_i} = '0;
        {setting_i, encoder_mode_i, err_i, card_found_i, card_apply_i,
         card_ok_i, card_restart_i, addr_reset_done_i} = '0;
        warn1_off_i = 1'b1;
        area_i = 8'h05;
        do_reset();
        t_reset();
        t_lamps();
        t_areas();
        t_scroll();
        t_codes();
        t_irq();
        t_invert();
        t_restart();
        conclude();
    end
endmodule
